// File: dv/dpbfc_checker.sv
`timescale 1ns/100ps
module dpbfc_checker (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire [31:0] ramp_freq_i,
  input wire decel_i,
  input wire [31:0] out_freq_o,
  input wire hold_active_o,
  input wire sleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i;

  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_follow: assert property (req && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_ack_cause: assert property (ack_o |-> $past(req) && !$past(ack_o))
    else $error("ack without a fresh request");
  a_upper_zero: assert property (dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  // The first edge after reset still sees the cleared output
  a_out_ramp: assert property (!hold_active_o && !$past(rst_i) |->
    out_freq_o == $past(ramp_freq_i))
    else $error("output does not follow ramp outside hold");
  a_hold_decel: assert property (hold_active_o |-> $past(decel_i))
    else $error("hold without deceleration");
  a_hold_enter: assert property ($rose(hold_active_o) |->
    $past(ramp_freq_i) <= out_freq_o)
    else $error("hold entered above hold frequency");
  a_hold_steady: assert property (hold_active_o && $past(hold_active_o)
    |-> $stable(out_freq_o))
    else $error("output moved during hold");

  c_access: cover property (req && ack_o);
  c_hold: cover property ($rose(hold_active_o));
  c_sleep: cover property ($rose(sleep_o));
endmodule // dpbfc_checker

bind dpbfc_top dpbfc_checker u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .ramp_freq_i(ramp_freq_i),
  .decel_i(decel_i),
  .out_freq_o(out_freq_o),
  .hold_active_o(hold_active_o),
  .sleep_o(sleep_o)
);

// File: dv/dpbfc_host.sv
`timescale 1ns/100ps
module dpbfc_host (
  input wire clk_i,
  input wire ack_i,
  input wire [31:0] rdat_i,
  output reg [15:0] adr_o = 16'h0000,
  output reg [31:0] dat_o = 32'h0000_0000,
  output reg we_o = 1'h0,
  output reg [3:0] sel_o = 4'h0,
  output reg cyc_o = 1'h0,
  output reg stb_o = 1'h0
);
  task xfer(input [13:0] idx, input w, input [15:0] d, output [15:0] q);
    begin
      adr_o <= {idx, 2'h0};
      dat_o <= {16'h0000, d};
      we_o <= w;
      sel_o <= 4'h3;
      cyc_o <= 1'h1;
      stb_o <= 1'h1;
      @(posedge clk_i);
      while (ack_i !== 1'h1) @(posedge clk_i);
      q = rdat_i[15:0];
      cyc_o <= 1'h0;
      stb_o <= 1'h0;
      // Released write data must not look like a held value
      dat_o <= ~dat_o;
      @(posedge clk_i);
    end
  endtask

  // Staged high half must precede the committing low half
  task wr32(input [13:0] hi, input [31:0] val);
    reg [15:0] q;
    begin
      xfer(hi, 1'h1, val[31:16], q);
      xfer(hi + 14'h0001, 1'h1, val[15:0], q);
    end
  endtask
endmodule // dpbfc_host

// File: dv/tb_drive_param_bank_freq_calc.sv
`timescale 1ns/100ps
`include "dpbfc_regs.vh"
module tb_drive_param_bank_freq_calc;
  reg clk_i = 1'h0;
  reg rst_i = 1'h1;
  reg [31:0] src [0:7];
  reg [31:0] first_freq_i = 32'h0000_0000;
  reg [31:0] ramp_freq_i = 32'h0000_0000;
  reg [31:0] pid_freq_i = 32'h0000_ffff;
  reg [9:0] pot_level_i = 10'h000;
  reg decel_i = 1'h0;
  wire [15:0] adr_i;
  wire [31:0] dat_i;
  wire [31:0] dat_o;
  wire we_i;
  wire [3:0] sel_i;
  wire cyc_i;
  wire stb_i;
  wire ack_o;
  wire [31:0] cmd_freq_o;
  wire [31:0] out_freq_o;
  wire [31:0] pot_freq_o;
  wire hold_active_o;
  wire sleep_o;
  integer errors = 0;
  integer samples_checked = 0;
  integer seed = 32'hfbe9;
  integer cycles = 0;
  integer i, k, n, v, s, o, g, e;
  reg [15:0] q;
  int ix [13] = '{'h12b0, 'h12b1, 'h12b5, 'h12b9, 'h12ba, 'h12bb, 'h12bc,
    'h12bf, 'h12c2, 'h12ca, 'h12cb, 'h12cc, 'h1400};
  int mx [13] = '{7, 2, 1, 50, 50, 50, 50, 600, 255, 100, 100, 1, 1};
  int mdl [13];

  dpbfc_top #(.POT_W(10), .TENTH_CYCLES(32'h0000_000a)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .first_freq_i(first_freq_i),
    .src_operator_i(src[0]), .src_voltage_i(src[2]), .src_current_i(src[3]),
    .src_comm_i(src[4]), .src_option_i(src[5]), .src_pulse_i(src[7]),
    .pot_level_i(pot_level_i), .ramp_freq_i(ramp_freq_i),
    .decel_i(decel_i), .pid_freq_i(pid_freq_i), .cmd_freq_o(cmd_freq_o),
    .out_freq_o(out_freq_o), .pot_freq_o(pot_freq_o),
    .hold_active_o(hold_active_o), .sleep_o(sleep_o));
  dpbfc_host u_host (.clk_i(clk_i), .ack_i(ack_o), .rdat_i(dat_o),
    .adr_o(adr_i), .dat_o(dat_i), .we_o(we_i), .sel_o(sel_i),
    .cyc_o(cyc_i), .stb_o(stb_i));

  always #5 clk_i = ~clk_i;

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task pair(input [13:0] a, input [31:0] val, input [31:0] exp);
    reg [15:0] h;
    reg [15:0] l;
    begin
      u_host.wr32(a, val);
      u_host.xfer(a, 1'h0, 16'h0000, h);
      u_host.xfer(a + 14'h0001, 1'h0, 16'h0000, l);
      chk({h, l}, exp);
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      results;
    end
  end

  initial begin
    foreach (src[j]) src[j] = 32'h0000_0000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    for (i = 0; i < 13; i++) begin
      mdl[i] = 0;
      u_host.xfer(ix[i], 1'h0, 16'h0000, q);
      chk(q, 0);
      for (k = 0; k < 4; k++) begin
        v = (k == 3) ? mx[i] + 1 : {$random(seed)} % (mx[i] + 1);
        if (i == 0 && k == 2) v = 6;
        if (v <= mx[i] && !(i == 0 && v == 6)) mdl[i] = v;
        u_host.xfer(ix[i], 1'h1, v[15:0], q);
        u_host.xfer(ix[i], 1'h0, 16'h0000, q);
        chk(q, mdl[i]);
      end
    end
    u_host.xfer(14'h12b2, 1'h1, 16'h5a5a, q);
    u_host.xfer(14'h12b2, 1'h0, 16'h0000, q);
    chk(q, 0);
    $display("test single registers done");
    u_host.xfer(14'h1400, 1'h1, 16'h0000, q);
    pair(14'h12b3, `DPB_FMAX_STD, `DPB_FMAX_STD);
    pair(14'h12b3, `DPB_FMAX_STD + 1, `DPB_FMAX_STD);
    u_host.xfer(14'h1400, 1'h1, 16'h0001, q);
    pair(14'h12b3, `DPB_FMAX_EXT, `DPB_FMAX_EXT);
    pair(14'h12b3, `DPB_FMAX_EXT + 1, `DPB_FMAX_EXT);
    u_host.xfer(14'h1400, 1'h1, 16'h0000, q);
    pair(14'h12b3, 32'h0000_0064, 32'h0000_0064);
    $display("test pairs done");
    pair(14'h12c6, 32'h0000_03e8, 32'h0000_03e8);
    pair(14'h12c8, 32'h0000_1388, 32'h0000_1388);
    u_host.xfer(14'h12ca, 1'h1, 16'h0014, q);
    u_host.xfer(14'h12cb, 1'h1, 16'h0050, q);
    pot_level_i <= 10'h064;
    for (g = 1; g >= 0; g--) begin
      u_host.xfer(14'h12cc, 1'h1, g[15:0], q);
      repeat (2) @(posedge clk_i);
      chk(pot_freq_o, g ? 0 : 32'h0000_03e8);
    end
    pot_level_i <= 10'h3ff;
    repeat (3) @(posedge clk_i);
    chk(pot_freq_o, 32'h0000_1388);
    // Mid-range: linear between start and end over the active span
    pot_level_i <= 10'h200;
    repeat (3) @(posedge clk_i);
    e = 1000 + 4000 * (512 * 100 - 20 * 1023) / (60 * 1023);
    chk(pot_freq_o, e);
    pot_level_i <= 10'h064;
    $display("test potentiometer done");
    for (s = 0; s < 8; s++) begin
      for (o = 0; o < 3; o++) begin
        for (g = 0; g < 2 && s != 6; g++) begin
          first_freq_i <= 32'h0000_07d0 + {$random(seed)} % 1000;
          foreach (src[j]) src[j] <= {$random(seed)} % 1000;
          u_host.xfer(14'h12b0, 1'h1, s[15:0], q);
          u_host.xfer(14'h12b1, 1'h1, o[15:0], q);
          u_host.xfer(14'h12b5, 1'h1, g[15:0], q);
          repeat (2) @(posedge clk_i);
          e = (s == 1) ? 32'h0000_03e8 : src[s];
          e = (o == 0) ? first_freq_i + e : (o == 1) ? first_freq_i - e :
            first_freq_i * e / 100;
          e = g ? (e > 100 ? e - 100 : 0) : e + 100;
          chk(cmd_freq_o, e);
        end
      end
    end
    $display("test command path done");
    pair(14'h12bd, 32'h0000_07d0, 32'h0000_07d0);
    u_host.xfer(14'h12bf, 1'h1, 16'h0002, q);
    ramp_freq_i <= 32'h0000_05dc;
    decel_i <= 1'h1;
    n = 0;
    while (hold_active_o !== 1'h1 && n < 5) begin
      @(posedge clk_i);
      n++;
    end
    chk(out_freq_o, 32'h0000_07d0);
    n = 0;
    while (hold_active_o === 1'h1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= 18 && n <= 22, 1);
    chk(out_freq_o, 32'h0000_05dc);
    decel_i <= 1'h0;
    $display("test hold done");
    pair(14'h12c0, 32'h0000_0bb8, 32'h0000_0bb8);
    u_host.xfer(14'h12c2, 1'h1, 16'h0003, q);
    pid_freq_i <= 32'h0000_09c4;
    n = 0;
    while (sleep_o !== 1'h1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= 28 && n <= 36, 1);
    u_host.xfer(14'h1401, 1'h0, 16'h0000, q);
    chk(q[1], 1);
    pid_freq_i <= 32'h0000_0fa0;
    repeat (3) @(posedge clk_i);
    chk(sleep_o, 0);
    $display("test sleep done");
    results;
  end
endmodule // tb_drive_param_bank_freq_calc

// File: hw/dpbfc_top.v
// Operation
// RL1: second source chosen by selector code
// RL2: combine sources by add, subtract, multiply
// RL3: added frequency held as high/low pair
// RL4: sign code adds or subtracts offset
// RL5: hold output at hold frequency during deceleration
// RL6: sleep only after trigger persists for delay
// RL7: potentiometer maps to start and end frequencies
// RL8: start/end percent bound potentiometer active range
// RL9: below range gives start frequency or zero
// RL10: pair writes; out-of-range writes keep old value
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`include "dpbfc_regs.vh"

module dpbfc_top #(
  parameter POT_W = 10,
  parameter [31:0] TENTH_CYCLES = `DPB_TENTH_SEC_NS / `DPB_CLK_PERIOD_NS
) (
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] adr_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire cyc_i,
  input wire stb_i,
  output wire ack_o,
  input wire [31:0] first_freq_i,
  input wire [31:0] src_operator_i,
  input wire [31:0] src_voltage_i,
  input wire [31:0] src_current_i,
  input wire [31:0] src_comm_i,
  input wire [31:0] src_option_i,
  input wire [31:0] src_pulse_i,
  input wire [POT_W-1:0] pot_level_i,
  input wire [31:0] ramp_freq_i,
  input wire decel_i,
  input wire [31:0] pid_freq_i,
  output reg [31:0] cmd_freq_o,
  output reg [31:0] out_freq_o,
  output reg [31:0] pot_freq_o,
  output reg hold_active_o,
  output reg sleep_o
);

  localparam NSC = 13;
  localparam NPR = 5;
  localparam [3:0] SC_SEL = 4'h0;
  localparam [3:0] SC_OP = 4'h1;
  localparam [3:0] SC_SIGN = 4'h2;
  localparam [3:0] SC_HTIME = 4'h7;
  localparam [3:0] SC_SDLY = 4'h8;
  localparam [3:0] SC_SPCT = 4'h9;
  localparam [3:0] SC_EPCT = 4'ha;
  localparam [3:0] SC_BELOW = 4'hb;
  localparam [3:0] SC_CTRL = 4'hc;
  localparam [2:0] PR_ADD = 3'h0;
  localparam [2:0] PR_HOLD = 3'h1;
  localparam [2:0] PR_SLEEP = 3'h2;
  localparam [2:0] PR_POTS = 3'h3;
  localparam [2:0] PR_POTE = 3'h4;
  localparam [63:0] POT_FS = (64'h1 << POT_W) - 64'h1;
  localparam [2:0] H_IDLE = 3'h1;
  localparam [2:0] H_HOLD = 3'h2;
  localparam [2:0] H_DONE = 3'h4;

  reg [15:0] sc [0:NSC-1];
  reg [31:0] pr [0:NPR-1];
  reg [15:0] shadow [0:NPR-1];
  reg ack;
  reg [31:0] rdat;
  integer i;

  wire [13:0] idx = adr_i[15:2];
  wire req = cyc_i & stb_i;
  wire [31:0] fmax = sc[SC_CTRL][`DPB_CTRL_EXT_BIT] ?
    `DPB_FMAX_EXT : `DPB_FMAX_STD;

  assign ack_o = ack;
  assign dat_o = rdat;

  // Address decode
  reg is_sc, is_hi, is_lo, is_stat;
  reg [3:0] sc_n;
  reg [2:0] pr_n;
  always @* begin
    is_sc = 1'b0;
    is_hi = 1'b0;
    is_lo = 1'b0;
    is_stat = 1'b0;
    sc_n = 4'h0;
    pr_n = 3'h0;
    if (idx == `DPB_IDX_SEC_SEL) begin
      is_sc = 1'b1;
      sc_n = SC_SEL;
    end else if (idx == `DPB_IDX_OPERATOR) begin
      is_sc = 1'b1;
      sc_n = SC_OP;
    end else if (idx == `DPB_IDX_ADD_SIGN) begin
      is_sc = 1'b1;
      sc_n = SC_SIGN;
    end else if (idx == `DPB_IDX_ACC_R1) begin
      is_sc = 1'b1;
      sc_n = 4'h3;
    end else if (idx == `DPB_IDX_ACC_R2) begin
      is_sc = 1'b1;
      sc_n = 4'h4;
    end else if (idx == `DPB_IDX_DEC_R1) begin
      is_sc = 1'b1;
      sc_n = 4'h5;
    end else if (idx == `DPB_IDX_DEC_R2) begin
      is_sc = 1'b1;
      sc_n = 4'h6;
    end else if (idx == `DPB_IDX_HOLD_TIME) begin
      is_sc = 1'b1;
      sc_n = SC_HTIME;
    end else if (idx == `DPB_IDX_SLEEP_DLY) begin
      is_sc = 1'b1;
      sc_n = SC_SDLY;
    end else if (idx == `DPB_IDX_POTS_PCT) begin
      is_sc = 1'b1;
      sc_n = SC_SPCT;
    end else if (idx == `DPB_IDX_POTE_PCT) begin
      is_sc = 1'b1;
      sc_n = SC_EPCT;
    end else if (idx == `DPB_IDX_POT_BELOW) begin
      is_sc = 1'b1;
      sc_n = SC_BELOW;
    end else if (idx == `DPB_IDX_CTRL) begin
      is_sc = 1'b1;
      sc_n = SC_CTRL;
    end else if (idx == `DPB_IDX_STATUS) begin
      is_stat = 1'b1;
    end else if (idx == `DPB_IDX_ADD_HI) begin
      is_hi = 1'b1;
      pr_n = PR_ADD;
    end else if (idx == `DPB_IDX_ADD_LO) begin
      is_lo = 1'b1;
      pr_n = PR_ADD;
    end else if (idx == `DPB_IDX_HOLD_HI) begin
      is_hi = 1'b1;
      pr_n = PR_HOLD;
    end else if (idx == `DPB_IDX_HOLD_LO) begin
      is_lo = 1'b1;
      pr_n = PR_HOLD;
    end else if (idx == `DPB_IDX_SLEEP_HI) begin
      is_hi = 1'b1;
      pr_n = PR_SLEEP;
    end else if (idx == `DPB_IDX_SLEEP_LO) begin
      is_lo = 1'b1;
      pr_n = PR_SLEEP;
    end else if (idx == `DPB_IDX_POTS_HI) begin
      is_hi = 1'b1;
      pr_n = PR_POTS;
    end else if (idx == `DPB_IDX_POTS_LO) begin
      is_lo = 1'b1;
      pr_n = PR_POTS;
    end else if (idx == `DPB_IDX_POTE_HI) begin
      is_hi = 1'b1;
      pr_n = PR_POTE;
    end else if (idx == `DPB_IDX_POTE_LO) begin
      is_lo = 1'b1;
      pr_n = PR_POTE;
    end
  end

  // Read value, write merge and range limit
  reg [15:0] rd16, cur16, wd16, lim16;
  always @* begin
    rd16 = 16'h0000;
    cur16 = 16'h0000;
    if (is_sc) begin
      rd16 = sc[sc_n];
      cur16 = sc[sc_n];
    end else if (is_hi) begin
      rd16 = pr[pr_n][31:16];
      cur16 = shadow[pr_n];
    end else if (is_lo) begin
      rd16 = pr[pr_n][15:0];
      cur16 = pr[pr_n][15:0];
    end else if (is_stat) begin
      rd16 = 16'h0000;
      rd16[`DPB_STAT_HOLD_BIT] = hold_active_o;
      rd16[`DPB_STAT_SLEEP_BIT] = sleep_o;
    end
    wd16[15:8] = sel_i[1] ? dat_i[15:8] : cur16[15:8];
    wd16[7:0] = sel_i[0] ? dat_i[7:0] : cur16[7:0];
    case (sc_n)
      SC_SEL: lim16 = `DPB_MAX_SEL;
      SC_OP: lim16 = `DPB_MAX_OPERATOR;
      SC_HTIME: lim16 = `DPB_MAX_HOLD_TIME;
      SC_SDLY: lim16 = `DPB_MAX_SLEEP_DLY;
      SC_SPCT: lim16 = `DPB_MAX_PCT;
      SC_EPCT: lim16 = `DPB_MAX_PCT;
      SC_SIGN: lim16 = `DPB_MAX_FLAG;
      SC_BELOW: lim16 = `DPB_MAX_FLAG;
      SC_CTRL: lim16 = `DPB_MAX_FLAG;
      default: lim16 = `DPB_MAX_RATIO;
    endcase
  end

  wire sc_ok = (wd16 <= lim16) &&
    !(sc_n == SC_SEL && wd16 == `DPB_SEL_HOLE); // RL1
  wire [31:0] pair_w = {shadow[pr_n], wd16};

  // Wishbone slave: ack one cycle after request, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
      for (i = 0; i < NSC; i = i + 1) begin
        sc[i] <= `DPB_RESET_VAL;
      end
      for (i = 0; i < NPR; i = i + 1) begin
        pr[i] <= 32'h0000_0000;
        shadow[i] <= `DPB_RESET_VAL;
      end
    end else begin
      ack <= req & ~ack;
      if (req & ~ack) begin
        rdat <= {16'h0000, rd16};
        if (we_i) begin
          if (is_sc && sc_ok) begin
            sc[sc_n] <= wd16; // RL10
          end else if (is_hi) begin
            shadow[pr_n] <= wd16; // RL3
          end else if (is_lo && pair_w <= fmax) begin
            pr[pr_n] <= pair_w; // RL10
          end
        end
      end
    end
  end

  // Potentiometer mapping; percent scaled against full ADC code
  reg [63:0] pos, lo_b, hi_b, span, pf, st_f, en_f;
  always @* begin
    st_f = {32'h0000_0000, pr[PR_POTS]};
    en_f = {32'h0000_0000, pr[PR_POTE]};
    pos = {{(64-POT_W){1'b0}}, pot_level_i} * `DPB_PCT_FULL;
    lo_b = {48'h0000_0000_0000, sc[SC_SPCT]} * POT_FS; // RL8
    hi_b = {48'h0000_0000_0000, sc[SC_EPCT]} * POT_FS; // RL8
    span = hi_b - lo_b;
    if (pos < lo_b) begin
      pf = (sc[SC_BELOW] == `DPB_RESET_VAL) ? st_f : 64'h0; // RL9
    end else if (pos >= hi_b) begin
      pf = en_f; // RL7
    end else if (en_f >= st_f) begin
      pf = st_f + ((en_f - st_f) * (pos - lo_b)) / span; // RL7
    end else begin
      pf = st_f - ((st_f - en_f) * (pos - lo_b)) / span; // RL7
    end
  end

  // Second source, combine and added offset
  reg [31:0] second;
  reg [63:0] comb, withoff, a64, b64, off64, fmax64;
  always @* begin
    case (sc[SC_SEL][2:0]) // RL1
      3'h0: second = src_operator_i;
      3'h1: second = pot_freq_o;
      3'h2: second = src_voltage_i;
      3'h3: second = src_current_i;
      3'h4: second = src_comm_i;
      3'h5: second = src_option_i;
      default: second = src_pulse_i;
    endcase
    a64 = {32'h0000_0000, first_freq_i};
    b64 = {32'h0000_0000, second};
    off64 = {32'h0000_0000, pr[PR_ADD]};
    fmax64 = {32'h0000_0000, fmax};
    // Results floor at zero and clip at the range top
    if (sc[SC_OP] == `DPB_OP_ADD) begin
      comb = a64 + b64; // RL2
    end else if (sc[SC_OP] == `DPB_OP_SUB) begin
      comb = (a64 > b64) ? a64 - b64 : 64'h0; // RL2
    end else begin
      comb = (a64 * b64) / `DPB_MUL_SCALE; // RL2
    end
    if (comb > fmax64) begin
      comb = fmax64;
    end
    if (sc[SC_SIGN] == `DPB_SIGN_SUB) begin
      withoff = (comb > off64) ? comb - off64 : 64'h0; // RL4
    end else begin
      withoff = comb + off64; // RL4
    end
    if (withoff > fmax64) begin
      withoff = fmax64;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pot_freq_o <= 32'h0000_0000;
      cmd_freq_o <= 32'h0000_0000;
    end else begin
      pot_freq_o <= pf[31:0];
      cmd_freq_o <= withoff[31:0];
    end
  end

  // Deceleration hold
  reg [2:0] hstate, next_hstate;
  reg [31:0] hpre;
  reg [15:0] htenths;
  wire htick = (hpre == TENTH_CYCLES - 32'h1);
  always @* begin
    next_hstate = hstate;
    case (hstate)
      H_IDLE: begin
        if (decel_i && sc[SC_HTIME] != 16'h0000 &&
            ramp_freq_i <= pr[PR_HOLD]) begin
          next_hstate = H_HOLD; // RL5
        end
      end
      H_HOLD: begin
        if (!decel_i) begin
          next_hstate = H_IDLE;
        end else if (htick && htenths + 16'h1 >= sc[SC_HTIME]) begin
          next_hstate = H_DONE; // RL5
        end
      end
      H_DONE: begin
        if (!decel_i) begin
          next_hstate = H_IDLE;
        end
      end
      default: next_hstate = H_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      hstate <= H_IDLE;
      hpre <= 32'h0000_0000;
      htenths <= 16'h0000;
      hold_active_o <= 1'b0;
      out_freq_o <= 32'h0000_0000;
    end else begin
      hstate <= next_hstate;
      if (hstate != H_HOLD || htick) begin
        hpre <= 32'h0000_0000;
      end else begin
        hpre <= hpre + 32'h1;
      end
      if (hstate != H_HOLD) begin
        htenths <= 16'h0000;
      end else if (htick) begin
        htenths <= htenths + 16'h1;
      end
      hold_active_o <= (next_hstate == H_HOLD);
      out_freq_o <= (next_hstate == H_HOLD) ? pr[PR_HOLD] :
        ramp_freq_i; // RL5
    end
  end

  // PID sleep: trigger must persist through the whole delay
  wire trig = pid_freq_i < pr[PR_SLEEP];
  reg [31:0] spre;
  reg [15:0] stenths;
  wire stick = (spre == TENTH_CYCLES - 32'h1);
  always @(posedge clk_i) begin
    if (rst_i) begin
      spre <= 32'h0000_0000;
      stenths <= 16'h0000;
      sleep_o <= 1'b0;
    end else if (!trig) begin
      spre <= 32'h0000_0000;
      stenths <= 16'h0000;
      sleep_o <= 1'b0; // RL6
    end else if (stenths >= sc[SC_SDLY]) begin
      sleep_o <= 1'b1; // RL6
    end else if (stick) begin
      spre <= 32'h0000_0000;
      stenths <= stenths + 16'h1;
    end else begin
      spre <= spre + 32'h1;
    end
  end

endmodule // dpbfc_top

// File: pkg/dpbfc_regs.vh
`ifndef DPBFC_REGS_VH
`define DPBFC_REGS_VH

// Register indices; byte address is four times the index
`define DPB_IDX_SEC_SEL 14'h12b0
`define DPB_IDX_OPERATOR 14'h12b1
`define DPB_IDX_ADD_HI 14'h12b3
`define DPB_IDX_ADD_LO 14'h12b4
`define DPB_IDX_ADD_SIGN 14'h12b5
`define DPB_IDX_ACC_R1 14'h12b9
`define DPB_IDX_ACC_R2 14'h12ba
`define DPB_IDX_DEC_R1 14'h12bb
`define DPB_IDX_DEC_R2 14'h12bc
`define DPB_IDX_HOLD_HI 14'h12bd
`define DPB_IDX_HOLD_LO 14'h12be
`define DPB_IDX_HOLD_TIME 14'h12bf
`define DPB_IDX_SLEEP_HI 14'h12c0
`define DPB_IDX_SLEEP_LO 14'h12c1
`define DPB_IDX_SLEEP_DLY 14'h12c2
`define DPB_IDX_POTS_HI 14'h12c6
`define DPB_IDX_POTS_LO 14'h12c7
`define DPB_IDX_POTE_HI 14'h12c8
`define DPB_IDX_POTE_LO 14'h12c9
`define DPB_IDX_POTS_PCT 14'h12ca
`define DPB_IDX_POTE_PCT 14'h12cb
`define DPB_IDX_POT_BELOW 14'h12cc
`define DPB_IDX_CTRL 14'h1400
`define DPB_IDX_STATUS 14'h1401

// Upper limits of written values
`define DPB_MAX_SEL 16'h0007
`define DPB_SEL_HOLE 16'h0006
`define DPB_MAX_OPERATOR 16'h0002
`define DPB_MAX_FLAG 16'h0001
`define DPB_MAX_RATIO 16'h0032
`define DPB_MAX_HOLD_TIME 16'h0258
`define DPB_MAX_SLEEP_DLY 16'h00ff
`define DPB_MAX_PCT 16'h0064
`define DPB_FMAX_STD 32'h0000_9c40
`define DPB_FMAX_EXT 32'h0001_86a0

// Codes
`define DPB_OP_ADD 16'h0000
`define DPB_OP_SUB 16'h0001
`define DPB_SIGN_SUB 16'h0001
`define DPB_CTRL_EXT_BIT 0
`define DPB_STAT_HOLD_BIT 0
`define DPB_STAT_SLEEP_BIT 1
`define DPB_RESET_VAL 16'h0000

// Scaling and timing
`define DPB_MUL_SCALE 64'h0000_0000_0000_0064
`define DPB_PCT_FULL 64'h0000_0000_0000_0064
`define DPB_TENTH_SEC_NS 32'h05f5_e100
`define DPB_CLK_PERIOD_NS 32'h0000_000a

`endif
